/* verilog/cq_regs_pkg.sv */
package cq_regs_pkg;
  localparam logic [11:0] OFS_CMD_PROD = 12'h098;
  localparam logic [11:0] OFS_CMD_CONS = 12'h09c;
  localparam logic [11:0] OFS_EVT_BASE_LO = 12'h0a0;
  localparam logic [11:0] OFS_EVT_BASE_HI = 12'h0a4;
  localparam logic [11:0] OFS_IRQ_ADDR_LO = 12'h0b0;
  localparam logic [11:0] OFS_IRQ_ADDR_HI = 12'h0b4;
  localparam int IDX_W = 20;
  localparam int LOG_W = 5;
  localparam int ERR_W = 7;
  localparam int ERR_LSB = 24;
  localparam int BASE_W = 47;
  localparam int BASE_LO_W = 27;
  localparam int BASE_LSB = 5;
  localparam int IRQ_W = 50;
  localparam int IRQ_LO_W = 30;
  localparam int IRQ_LSB = 2;
  localparam int HI_FIELD_W = 20;
  localparam int ALLOC_HI_BIT = 30;
  localparam logic [LOG_W-1:0] MAX_CMD_LOG = 5'h13;
  localparam logic [LOG_W-1:0] MAX_EVT_LOG = 5'h13;
  localparam logic [5:0] EVT_ENTRY_LOG = 6'h05;
  localparam logic [5:0] MIN_ALIGN_LOG = 6'h05;
  localparam logic [6:0] PA_SIZE = 7'h30;
  typedef enum logic [1:0] {CONS_RUN, CONS_ERR_LOAD, CONS_ERR_HOLD} cons_state_e;

  function automatic logic [IDX_W-1:0] idx_mask(input logic [LOG_W-1:0] lg);
    logic [IDX_W:0] m;
    m = (IDX_W+1)'(2) << lg;
    return m[IDX_W-1:0] - IDX_W'(1);
  endfunction : idx_mask

  function automatic logic [LOG_W-1:0] clamp_log(input logic [LOG_W-1:0] v,
                                                 input logic [LOG_W-1:0] mx);
    return (v > mx) ? mx : v;
  endfunction : clamp_log
endpackage : cq_regs_pkg

/* verilog/cq_ifs.sv */
`timescale 1ns/1ps
interface idx_if;
  logic [cq_regs_pkg::LOG_W-1:0] size_log;
  logic [cq_regs_pkg::IDX_W-1:0] rd_index;
  logic [cq_regs_pkg::IDX_W-1:0] wr_index;
  logic [cq_regs_pkg::IDX_W-1:0] rd_next;
  logic [cq_regs_pkg::IDX_W-1:0] rd_view;
  logic is_empty;
  logic is_full;
  modport calc (input size_log, input rd_index, input wr_index, output rd_next,
                output rd_view, output is_empty, output is_full);
  modport owner (output size_log, output rd_index, output wr_index, input rd_next,
                 input rd_view, input is_empty, input is_full);
endinterface : idx_if

interface evt_if;
  logic [cq_regs_pkg::BASE_W-1:0] base_field;
  logic [cq_regs_pkg::LOG_W-1:0] log_raw;
  logic [cq_regs_pkg::IRQ_W-1:0] irq_field;
  logic [51:0] base_eff;
  logic [cq_regs_pkg::LOG_W-1:0] log_eff;
  logic [63:0] msi_addr;
  logic msi_on;
  modport calc (input base_field, input log_raw, input irq_field, output base_eff,
                output log_eff, output msi_addr, output msi_on);
  modport owner (output base_field, output log_raw, output irq_field, input base_eff,
                 input log_eff, input msi_addr, input msi_on);
endinterface : evt_if

/* verilog/queue_index_step.sv */
`timescale 1ns/1ps
module queue_index_step (
  idx_if.calc idx // Index view, step and occupancy.
);
  logic [cq_regs_pkg::IDX_W-1:0] mask;
  logic [cq_regs_pkg::IDX_W-1:0] wr_view;
  logic [cq_regs_pkg::IDX_W-1:0] diff;

  // A plus one that carries out of the index bits toggles the wrap bit, and
  // a carry out of the wrap bit falls outside the mask.
  always_comb
  begin
    mask = cq_regs_pkg::idx_mask(idx.size_log);
    idx.rd_view = idx.rd_index & mask;
    wr_view = idx.wr_index & mask;
    idx.rd_next = (idx.rd_view + cq_regs_pkg::IDX_W'(1)) & mask;
    diff = idx.rd_view ^ wr_view;
    idx.is_empty = (diff == '0);
    idx.is_full = (diff == (mask ^ (mask >> 1)));
  end
endmodule : queue_index_step

/* verilog/evt_addr_calc.sv */
`timescale 1ns/1ps
module evt_addr_calc (
  evt_if.calc ev // Event queue address terms.
);
  logic [5:0] align_log;
  logic [51:0] align_mask;
  logic [63:0] pa_mask;

  always_comb
  begin
    ev.log_eff = cq_regs_pkg::clamp_log(ev.log_raw, cq_regs_pkg::MAX_EVT_LOG);
    align_log = 6'(ev.log_eff) + cq_regs_pkg::EVT_ENTRY_LOG;
    if (align_log < cq_regs_pkg::MIN_ALIGN_LOG)
    begin
      align_log = cq_regs_pkg::MIN_ALIGN_LOG;
    end
    align_mask = ~((52'h1 << align_log) - 52'h1);
    ev.base_eff = {ev.base_field, {cq_regs_pkg::BASE_LSB{1'b0}}} & align_mask;
    pa_mask = (64'h1 << cq_regs_pkg::PA_SIZE) - 64'h1;
    ev.msi_addr = {12'h0, ev.irq_field, {cq_regs_pkg::IRQ_LSB{1'b0}}} & pa_mask;
    ev.msi_on = (ev.msi_addr != 64'h0);
  end
endmodule : evt_addr_calc

/* verilog/cmd_event_queue_regs.sv */
`timescale 1ns/1ps
module cmd_event_queue_regs (
  input wire logic clk_sys, // System clock.
  input wire logic rst, // Synchronous reset, high.
  input wire logic reg_wr, // Register write strobe.
  input wire logic reg_rd, // Register read strobe.
  input wire logic [11:0] reg_addr, // Register byte offset.
  input wire logic [31:0] reg_wdata, // Write data.
  output logic [31:0] reg_rdata, // Read data.
  output logic reg_rvalid, // Read data valid pulse.
  input wire logic command_queue_enable, // Command queue enable.
  input wire logic cmdq_enable_ack, // Acknowledge of that enable.
  input wire logic event_queue_enable, // Event queue enable.
  input wire logic evtq_enable_ack, // Acknowledge of that enable.
  input wire logic event_queue_irq_enable, // Event queue interrupt enable.
  input wire logic evtq_irq_enable_ack, // Acknowledge of that enable.
  input wire logic queue_config_fixed, // Queue settings preset.
  input wire logic [4:0] queue_size_log, // Command queue log2 entries.
  input wire logic cmd_consumed, // Command consumed pulse.
  input wire logic cmd_fail, // Command failed pulse.
  input wire logic [6:0] cmd_fail_code, // Reason code with cmd_fail.
  input wire logic error_ack, // Software acknowledged the error.
  input wire logic event_queue_writable, // Event queue has room.
  output logic command_queue_error, // Command queue error active.
  output logic cmd_consume_allow, // Engine may consume commands.
  output logic cmd_fetch_kick, // Pulse: look at the queue.
  output logic cmd_queue_empty, // Command queue empty.
  output logic cmd_queue_full, // Command queue full.
  output logic [19:0] cmd_read_index, // Published read field.
  output logic event_write_allow, // Events may be written.
  output logic [51:0] event_base_addr, // Effective event base.
  output logic event_write_allocate, // Write allocate hint.
  output logic [4:0] event_queue_log_eff, // Clamped event log size.
  output logic [63:0] msi_target_addr, // Effective message address.
  output logic msi_send_enable // Message delivery enabled.
);

  ////////////////////////////////////////////////////////////////////////////
  // Register storage and helpers.

  logic [cq_regs_pkg::IDX_W-1:0] prod_reg;
  logic [cq_regs_pkg::IDX_W-1:0] prod_next;
  logic [cq_regs_pkg::IDX_W-1:0] rd_reg;
  logic [cq_regs_pkg::IDX_W-1:0] rd_next;
  logic [cq_regs_pkg::ERR_W-1:0] err_reg;
  logic [cq_regs_pkg::ERR_W-1:0] err_next;
  logic [cq_regs_pkg::BASE_W-1:0] evt_addr_reg;
  logic [cq_regs_pkg::BASE_W-1:0] evt_addr_next;
  logic [cq_regs_pkg::LOG_W-1:0] evt_log_reg;
  logic [cq_regs_pkg::LOG_W-1:0] evt_log_next;
  logic evt_alloc_reg;
  logic evt_alloc_next;
  logic [cq_regs_pkg::IRQ_W-1:0] irq_addr_reg;
  logic [cq_regs_pkg::IRQ_W-1:0] irq_addr_next;
  cq_regs_pkg::cons_state_e state_reg;
  cq_regs_pkg::cons_state_e state_next;
  logic cons_wr_ok;
  logic base_wr_ok;
  logic irq_wr_ok;
  logic prod_wr;
  logic fail_take;
  logic consume_take;

  idx_if idx ();
  evt_if ev ();

  queue_index_step u_step (
    .idx(idx)
  );

  evt_addr_calc u_addr (
    .ev(ev)
  );

  assign idx.size_log = cq_regs_pkg::clamp_log(queue_size_log, cq_regs_pkg::MAX_CMD_LOG);
  assign idx.rd_index = rd_reg;
  assign idx.wr_index = prod_reg;
  assign ev.base_field = evt_addr_reg;
  assign ev.log_raw = evt_log_reg;
  assign ev.irq_field = irq_addr_reg;

  assign cons_wr_ok = !command_queue_enable && !cmdq_enable_ack;
  assign base_wr_ok = !queue_config_fixed && !event_queue_enable && !evtq_enable_ack;
  assign irq_wr_ok = !event_queue_irq_enable && !evtq_irq_enable_ack;
  assign prod_wr = reg_wr && (reg_addr == cq_regs_pkg::OFS_CMD_PROD);
  assign fail_take = cmd_fail && cmd_consume_allow && (state_reg == cq_regs_pkg::CONS_RUN);
  assign consume_take = cmd_consumed && cmd_consume_allow && !cmd_fail &&
                        (state_reg == cq_regs_pkg::CONS_RUN) && !idx.is_empty;

  ////////////////////////////////////////////////////////////////////////////
  // Register writes, consumption and the error sequence.

  always_comb
  begin
    prod_next = prod_reg;
    rd_next = rd_reg;
    err_next = err_reg;
    evt_addr_next = evt_addr_reg;
    evt_log_next = evt_log_reg;
    evt_alloc_next = evt_alloc_reg;
    irq_addr_next = irq_addr_reg;
    state_next = state_reg;
    // Every consumed entry is published at once, so the bound is two cycles: rd_reg on the next edge, cmd_read_index one edge later.
    if (consume_take)
    begin
      rd_next = idx.rd_next;
    end
    if (reg_wr)
    begin
      unique case (reg_addr)
        cq_regs_pkg::OFS_CMD_PROD:
        begin
          prod_next = reg_wdata[cq_regs_pkg::IDX_W-1:0];
        end
        cq_regs_pkg::OFS_CMD_CONS:
        begin
          if (cons_wr_ok)
          begin
            rd_next = reg_wdata[cq_regs_pkg::IDX_W-1:0];
            err_next = reg_wdata[cq_regs_pkg::ERR_LSB +: cq_regs_pkg::ERR_W];
          end
        end
        cq_regs_pkg::OFS_EVT_BASE_LO:
        begin
          if (base_wr_ok)
          begin
            evt_addr_next[cq_regs_pkg::BASE_LO_W-1:0] = reg_wdata[31:cq_regs_pkg::BASE_LSB];
            evt_log_next = reg_wdata[cq_regs_pkg::LOG_W-1:0];
          end
        end
        cq_regs_pkg::OFS_EVT_BASE_HI:
        begin
          if (base_wr_ok)
          begin
            evt_addr_next[cq_regs_pkg::BASE_W-1:cq_regs_pkg::BASE_LO_W] =
              reg_wdata[cq_regs_pkg::HI_FIELD_W-1:0];
            evt_alloc_next = reg_wdata[cq_regs_pkg::ALLOC_HI_BIT];
          end
        end
        cq_regs_pkg::OFS_IRQ_ADDR_LO:
        begin
          if (irq_wr_ok)
          begin
            irq_addr_next[cq_regs_pkg::IRQ_LO_W-1:0] = reg_wdata[31:cq_regs_pkg::IRQ_LSB];
          end
        end
        cq_regs_pkg::OFS_IRQ_ADDR_HI:
        begin
          if (irq_wr_ok)
          begin
            irq_addr_next[cq_regs_pkg::IRQ_W-1:cq_regs_pkg::IRQ_LO_W] =
              reg_wdata[cq_regs_pkg::HI_FIELD_W-1:0];
          end
        end
        default:
        begin
        end
      endcase
    end
    // A failure outranks a software write of the code in the same cycle.
    unique case (state_reg)
      cq_regs_pkg::CONS_RUN:
      begin
        if (fail_take)
        begin
          err_next = cmd_fail_code;
          state_next = cq_regs_pkg::CONS_ERR_LOAD;
        end
      end
      cq_regs_pkg::CONS_ERR_LOAD:
      begin
        state_next = cq_regs_pkg::CONS_ERR_HOLD;
      end
      cq_regs_pkg::CONS_ERR_HOLD:
      begin
        if (error_ack)
        begin
          state_next = cq_regs_pkg::CONS_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      prod_reg <= '0;
      rd_reg <= '0;
      err_reg <= '0;
      evt_addr_reg <= '0;
      evt_log_reg <= '0;
      evt_alloc_reg <= 1'b0;
      irq_addr_reg <= '0;
      state_reg <= cq_regs_pkg::CONS_RUN;
    end
    else
    begin
      prod_reg <= prod_next;
      rd_reg <= rd_next;
      err_reg <= err_next;
      evt_addr_reg <= evt_addr_next;
      evt_log_reg <= evt_log_next;
      evt_alloc_reg <= evt_alloc_next;
      irq_addr_reg <= irq_addr_next;
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port and registered outputs.

  logic [31:0] rdata_next;
  logic error_next;
  logic allow_next;
  logic kick_next;

  always_comb
  begin
    rdata_next = 32'h0;
    unique case (reg_addr)
      cq_regs_pkg::OFS_CMD_PROD:
      begin
        rdata_next = 32'(prod_reg);
      end
      cq_regs_pkg::OFS_CMD_CONS:
      begin
        rdata_next = {1'b0, err_reg, 4'h0, idx.rd_view};
      end
      cq_regs_pkg::OFS_EVT_BASE_LO:
      begin
        rdata_next = {evt_addr_reg[cq_regs_pkg::BASE_LO_W-1:0], evt_log_reg};
      end
      cq_regs_pkg::OFS_EVT_BASE_HI:
      begin
        rdata_next = {1'b0, evt_alloc_reg, 10'h0,
                      evt_addr_reg[cq_regs_pkg::BASE_W-1:cq_regs_pkg::BASE_LO_W]};
      end
      cq_regs_pkg::OFS_IRQ_ADDR_LO:
      begin
        rdata_next = {irq_addr_reg[cq_regs_pkg::IRQ_LO_W-1:0], 2'h0};
      end
      cq_regs_pkg::OFS_IRQ_ADDR_HI:
      begin
        rdata_next = {12'h0, irq_addr_reg[cq_regs_pkg::IRQ_W-1:cq_regs_pkg::IRQ_LO_W]};
      end
      default:
      begin
        rdata_next = 32'h0;
      end
    endcase
    error_next = (state_next == cq_regs_pkg::CONS_ERR_HOLD);
    allow_next = (state_next == cq_regs_pkg::CONS_RUN) && command_queue_enable;
    kick_next = prod_wr && command_queue_enable && !command_queue_error &&
                (state_reg == cq_regs_pkg::CONS_RUN);
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      reg_rdata <= 32'h0;
      reg_rvalid <= 1'b0;
      command_queue_error <= 1'b0;
      cmd_consume_allow <= 1'b0;
      cmd_fetch_kick <= 1'b0;
      cmd_queue_empty <= 1'b1;
      cmd_queue_full <= 1'b0;
      cmd_read_index <= '0;
      event_write_allow <= 1'b0;
      event_base_addr <= '0;
      event_write_allocate <= 1'b0;
      event_queue_log_eff <= '0;
      msi_target_addr <= '0;
      msi_send_enable <= 1'b0;
    end
    else
    begin
      reg_rdata <= reg_rd ? rdata_next : 32'h0;
      reg_rvalid <= reg_rd;
      command_queue_error <= error_next;
      cmd_consume_allow <= allow_next;
      cmd_fetch_kick <= kick_next;
      cmd_queue_empty <= idx.is_empty;
      cmd_queue_full <= idx.is_full;
      cmd_read_index <= idx.rd_view;
      event_write_allow <= event_queue_enable && event_queue_writable;
      event_base_addr <= ev.base_eff;
      event_write_allocate <= evt_alloc_reg;
      event_queue_log_eff <= ev.log_eff;
      msi_target_addr <= ev.msi_addr;
      msi_send_enable <= ev.msi_on;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  sequence fail_seen;
    fail_take;
  endsequence

  sequence code_then_error;
    !command_queue_error && (state_reg == cq_regs_pkg::CONS_ERR_LOAD) ##1
      command_queue_error && (err_reg == $past(cmd_fail_code, 2));
  endsequence

  err_code_order_a: assert property (@(posedge clk_sys) disable iff (rst)
    fail_seen |=> code_then_error)
    else $error("error raised before its reason code");

  rd_stays_err_a: assert property (@(posedge clk_sys) disable iff (rst)
    (state_reg != cq_regs_pkg::CONS_RUN) && !(reg_wr && cons_wr_ok) |=> $stable(rd_reg))
    else $error("read index moved during an error");

  no_consume_err_a: assert property (@(posedge clk_sys) disable iff (rst)
    command_queue_error |-> !cmd_consume_allow)
    else $error("consumption allowed during an error");

  resume_ack_a: assert property (@(posedge clk_sys) disable iff (rst)
    command_queue_error && error_ack && command_queue_enable
      |=> cmd_consume_allow && !command_queue_error)
    else $error("no resume after acknowledge");

  enable_keeps_err_a: assert property (@(posedge clk_sys) disable iff (rst)
    command_queue_error && !error_ack |=> command_queue_error)
    else $error("error cleared without acknowledge");

  rd_step_a: assert property (@(posedge clk_sys) disable iff (rst)
    consume_take && !reg_wr && $stable(idx.size_log) |=> idx.rd_view ==
      ((($past(idx.rd_view) + 20'h1)) & cq_regs_pkg::idx_mask(idx.size_log)))
    else $error("read index step wrong");

  cons_guard_a: assert property (@(posedge clk_sys) disable iff (rst)
    reg_wr && (reg_addr == cq_regs_pkg::OFS_CMD_CONS) && !cons_wr_ok && !consume_take
      && !fail_take |=> $stable(rd_reg) && $stable(err_reg))
    else $error("consumer written while guarded");

  base_guard_a: assert property (@(posedge clk_sys) disable iff (rst)
    reg_wr && !base_wr_ok |=> $stable(evt_addr_reg) && $stable(evt_log_reg)
      && $stable(evt_alloc_reg))
    else $error("event base written while guarded");

  kick_cond_a: assert property (@(posedge clk_sys) disable iff (rst)
    cmd_fetch_kick |-> $past(prod_wr) && $past(command_queue_enable)
      && !$past(command_queue_error))
    else $error("kick without a valid producer write");

  evt_gate_a: assert property (@(posedge clk_sys) disable iff (rst)
    !event_queue_enable |=> !event_write_allow)
    else $error("events allowed while disabled");

  ack_disabled_a: assert property (@(posedge clk_sys) disable iff (rst)
    command_queue_error && error_ack && !command_queue_enable |=> !cmd_consume_allow)
    else $error("consumption resumed while the queue was disabled");

endmodule : cmd_event_queue_regs

/* verification/cmd_engine_model.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Behavioural command engine standing on the consumer side of the queue.
module cmd_engine_model (
  input wire logic clk_sys, // System clock.
  input wire logic allow, // Consumption permitted.
  input wire logic empty, // Queue empty.
  output logic cmd_consumed, // Consumed pulse.
  output logic cmd_fail, // Failure pulse.
  output logic [6:0] cmd_fail_code // Reason with the failure.
);
  initial
  begin
    cmd_consumed = 1'b0;
    cmd_fail = 1'b0;
    cmd_fail_code = 7'h00;
  end

  // With any set, the pulse is sent even when consumption is forbidden.
  task automatic consume(input int n, input bit any);
    repeat (n)
    begin
      @(negedge clk_sys);
      cmd_consumed = any | (allow & ~empty);
      @(negedge clk_sys);
      cmd_consumed = 1'b0;
    end
  endtask : consume

  // The code is inverted after the pulse so a stale value is never mistaken for a hold.
  task automatic fail(input logic [6:0] code);
    @(negedge clk_sys);
    cmd_fail = 1'b1;
    cmd_fail_code = code;
    @(negedge clk_sys);
    cmd_fail = 1'b0;
    cmd_fail_code = ~code;
  endtask : fail
endmodule : cmd_engine_model

/* verification/test_cmd_event_queue_regs.sv */
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
  begin \
    n_tests++; \
    if ((got) !== (exp)) \
    begin \
      $display("MISMATCH %s exp=%h got=%h", nm, exp, got); \
      n_errors++; \
    end \
  end
////////////////////////////////////////////////////////////////////////////////
module test_cmd_event_queue_regs;
  typedef struct {logic [11:0] a; logic [31:0] d; logic [31:0] e;} row_s;
  logic clk_sys, rst, reg_wr, reg_rd, reg_rvalid, kick;
  logic [11:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rv;
  logic command_queue_enable, cmdq_enable_ack, event_queue_enable, evtq_enable_ack;
  logic event_queue_irq_enable, evtq_irq_enable_ack, queue_config_fixed;
  logic [4:0] queue_size_log, event_queue_log_eff;
  logic cmd_consumed, cmd_fail, error_ack, event_queue_writable;
  logic [6:0] cmd_fail_code;
  logic command_queue_error, cmd_consume_allow, cmd_fetch_kick, cmd_queue_empty;
  logic cmd_queue_full, event_write_allow, event_write_allocate, msi_send_enable;
  logic [19:0] cmd_read_index;
  logic [51:0] event_base_addr;
  logic [63:0] msi_target_addr;
  int n_errors = 0;
  int n_tests = 0;
  row_s rows [7] = '{
    '{12'h098, 32'hfff1_2345, 32'h0001_2345},
    '{12'h09c, 32'hff5f_fffa, 32'h7f00_000a},
    '{12'h0a0, 32'habcd_e1e7, 32'habcd_e1e7},
    '{12'h0a4, 32'h4000_0000, 32'h4000_0000},
    '{12'h0b0, 32'hffff_ffff, 32'hffff_fffc},
    '{12'h0b4, 32'hffff_ffff, 32'h000f_ffff},
    '{12'h0a8, 32'hffff_ffff, 32'h0000_0000}};

  cmd_event_queue_regs dut_u (.clk_sys(clk_sys), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .command_queue_enable(command_queue_enable),
    .cmdq_enable_ack(cmdq_enable_ack), .event_queue_enable(event_queue_enable),
    .evtq_enable_ack(evtq_enable_ack), .event_queue_irq_enable(event_queue_irq_enable),
    .evtq_irq_enable_ack(evtq_irq_enable_ack), .queue_config_fixed(queue_config_fixed),
    .queue_size_log(queue_size_log), .cmd_consumed(cmd_consumed), .cmd_fail(cmd_fail),
    .cmd_fail_code(cmd_fail_code), .error_ack(error_ack),
    .event_queue_writable(event_queue_writable), .command_queue_error(command_queue_error),
    .cmd_consume_allow(cmd_consume_allow), .cmd_fetch_kick(cmd_fetch_kick),
    .cmd_queue_empty(cmd_queue_empty), .cmd_queue_full(cmd_queue_full),
    .cmd_read_index(cmd_read_index), .event_write_allow(event_write_allow),
    .event_base_addr(event_base_addr), .event_write_allocate(event_write_allocate),
    .event_queue_log_eff(event_queue_log_eff), .msi_target_addr(msi_target_addr),
    .msi_send_enable(msi_send_enable));

  cmd_engine_model eng_u (.clk_sys(clk_sys), .allow(cmd_consume_allow),
    .empty(cmd_queue_empty), .cmd_consumed(cmd_consumed), .cmd_fail(cmd_fail),
    .cmd_fail_code(cmd_fail_code));

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic end_sim();
    $display("counts tests=%0d errors=%0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_sim

  // The kick pulse is caught in the cycle after the write is taken.
  task automatic wr32(input logic [11:0] a, input logic [31:0] d);
    @(negedge clk_sys);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk_sys);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
    kick = cmd_fetch_kick;
  endtask : wr32

  task automatic rd32(input logic [11:0] a, output logic [31:0] d);
    @(negedge clk_sys);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    reg_addr = ~a;
    `CHK("rvalid", 1'b1, reg_rvalid)
    d = reg_rdata;
  endtask : rd32

  task automatic wait_n(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : wait_n

  task automatic set_cmd_en(input logic v);
    @(negedge clk_sys);
    command_queue_enable = v;
    cmdq_enable_ack = v;
  endtask : set_cmd_en

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #200000;
    n_errors++;
    end_sim();
  end

  initial
  begin
    {rst, reg_wr, reg_rd, error_ack, queue_config_fixed} = 5'h10;
    {command_queue_enable, cmdq_enable_ack, event_queue_enable, evtq_enable_ack} = 4'h0;
    {event_queue_irq_enable, evtq_irq_enable_ack, event_queue_writable} = 3'h1;
    reg_addr = 12'h000;
    reg_wdata = 32'h0000_0000;
    queue_size_log = 5'h03;
    kick = 1'b0;
    repeat (16) @(negedge clk_sys);
    rst = 1'b0;
    `CHK("empty_rst", 1'b1, cmd_queue_empty)
    `CHK("err_rst", 1'b0, command_queue_error)
    $display("TEST reset done");
    // Indices first, then event base and size, then message address, then an unmapped offset.
    for (int i = 0; i < 7; i++)
    begin
      wr32(rows[i].a, rows[i].d);
      rd32(rows[i].a, rv);
      `CHK("readback", rows[i].e, rv)
    end
    wait_n(2);
    `CHK("alloc", 1'b1, event_write_allocate)
    `CHK("log_eff", 5'h07, event_queue_log_eff)
    `CHK("base_eff", 52'h0_0000_abcd_e000, event_base_addr)
    `CHK("msi_addr", 64'h0000_ffff_ffff_fffc, msi_target_addr)
    `CHK("msi_on", 1'b1, msi_send_enable)
    $display("TEST table done");
    wr32(12'h0a0, 32'h0000_001f);
    wait_n(2);
    `CHK("log_clamp", 5'h13, event_queue_log_eff)
    for (int i = 0; i < 3; i++)
    begin
      {event_queue_enable, evtq_enable_ack, queue_config_fixed} = 3'b100 >> i;
      wr32(12'h0a0, 32'h0000_0003);
      rd32(12'h0a0, rv);
      `CHK("base_guard", 32'h0000_001f, rv)
      `CHK("evt_allow", (i == 0), event_write_allow)
    end
    event_queue_enable = 1'b1;
    event_queue_writable = 1'b0;
    wait_n(2);
    `CHK("evt_block", 1'b0, event_write_allow)
    {event_queue_enable, evtq_enable_ack, queue_config_fixed} = 3'b000;
    wr32(12'h0a0, 32'h0000_0003);
    rd32(12'h0a0, rv);
    `CHK("base_open", 32'h0000_0003, rv)
    for (int i = 0; i < 2; i++)
    begin
      {event_queue_irq_enable, evtq_irq_enable_ack} = 2'b10 >> i;
      wr32(12'h0b0, 32'h0000_0000);
      rd32(12'h0b0, rv);
      `CHK("irq_guard", 32'hffff_fffc, rv)
    end
    {event_queue_irq_enable, evtq_irq_enable_ack} = 2'b00;
    wr32(12'h0b0, 32'h0000_0000);
    wr32(12'h0b4, 32'h0000_0000);
    wait_n(2);
    `CHK("msi_off", 1'b0, msi_send_enable)
    $display("TEST event regs done");
    queue_size_log = 5'h01;
    wr32(12'h09c, 32'h0000_0000);
    wr32(12'h098, 32'h0000_0002);
    `CHK("kick_off", 1'b0, kick)
    set_cmd_en(1'b1);
    wr32(12'h09c, 32'h0000_0001);
    wait_n(2);
    `CHK("full", 1'b1, cmd_queue_full)
    `CHK("cons_ro", 20'h00000, cmd_read_index)
    eng_u.consume(2, 1'b0);
    wait_n(3);
    `CHK("rd_wrap", 20'h00002, cmd_read_index)
    `CHK("empty", 1'b1, cmd_queue_empty)
    wr32(12'h098, 32'h0000_0003);
    `CHK("kick_on", 1'b1, kick)
    eng_u.fail(7'h55);
    wait_n(3);
    `CHK("err_on", 1'b1, command_queue_error)
    `CHK("allow_off", 1'b0, cmd_consume_allow)
    rd32(12'h09c, rv);
    `CHK("err_code", 32'h5500_0002, rv)
    eng_u.consume(1, 1'b1);
    wait_n(3);
    `CHK("rd_hold", 20'h00002, cmd_read_index)
    set_cmd_en(1'b0);
    set_cmd_en(1'b1);
    wait_n(2);
    `CHK("err_stay", 1'b1, command_queue_error)
    wr32(12'h098, 32'h0000_0003);
    `CHK("kick_err", 1'b0, kick)
    @(negedge clk_sys);
    error_ack = 1'b1;
    @(negedge clk_sys);
    error_ack = 1'b0;
    wait_n(2);
    `CHK("err_clr", 1'b0, command_queue_error)
    `CHK("allow_on", 1'b1, cmd_consume_allow)
    $display("TEST command flow done");
    set_cmd_en(1'b0);
    queue_size_log = 5'h00;
    wait_n(2);
    `CHK("shrink", 20'h00000, cmd_read_index)
    wr32(12'h09c, 32'h0000_0000);
    wr32(12'h098, 32'h0000_0001);
    set_cmd_en(1'b1);
    wait_n(2);
    `CHK("one_full", 1'b1, cmd_queue_full)
    eng_u.consume(1, 1'b0);
    wait_n(3);
    `CHK("one_wrap", 20'h00001, cmd_read_index)
    $display("TEST single entry done");
    eng_u.fail(7'h2a);
    set_cmd_en(1'b0);
    @(negedge clk_sys);
    error_ack = 1'b1;
    @(negedge clk_sys);
    error_ack = 1'b0;
    wait_n(2);
    `CHK("ack_off_err", 1'b0, command_queue_error)
    `CHK("ack_off_allow", 1'b0, cmd_consume_allow)
    cmdq_enable_ack = 1'b1;
    wr32(12'h09c, 32'h0000_0000);
    rd32(12'h09c, rv);
    `CHK("cons_ack_ro", 32'h2a00_0001, rv)
    $display("TEST ack while disabled done");
    end_sim();
  end
endmodule : test_cmd_event_queue_regs
